// file: hdl/uem_consts.vh
// Constants for the endpoint mode responder: offsets, fields, codes
`ifndef UEM_CONSTS_VH
`define UEM_CONSTS_VH
// Register byte offsets
`define UEM_OFS_MODE 6'h00
`define UEM_OFS_COUNT 6'h04
`define UEM_OFS_CONFIG 6'h08
`define UEM_OFS_STATUS 6'h0c
`define UEM_OFS_BUF 6'h20
// Mode register fields
`define UEM_MB_SETUP 7
`define UEM_MB_IN 6
`define UEM_MB_OUT 5
`define UEM_MB_ACK 4
`define UEM_MB_STALL 7
// Count register fields
`define UEM_CB_TOG 7
`define UEM_CB_DVAL 6
// Reset values
`define UEM_RST_MODE 8'h00
`define UEM_RST_COUNT 8'h00
`define UEM_RST_CTRL 1'b1
// Endpoint modes
`define UEM_M_DIS 4'h0
`define UEM_M_NAK_IO 4'h1
`define UEM_M_ST_OUT 4'h2
`define UEM_M_STALL_IO 4'h3
`define UEM_M_IGN_IO 4'h4
`define UEM_M_ISO_OUT 4'h5
`define UEM_M_ST_IN 4'h6
`define UEM_M_ISO_IN 4'h7
`define UEM_M_NAK_OUT 4'h8
`define UEM_M_ACK_OUT 4'h9
`define UEM_M_NAK_OUT_SI 4'ha
`define UEM_M_ACK_OUT_SI 4'hb
`define UEM_M_NAK_IN 4'hc
`define UEM_M_ACK_IN 4'hd
`define UEM_M_NAK_IN_SO 4'he
`define UEM_M_ACK_IN_SO 4'hf
// Token codes
`define UEM_PID_OUT 2'h1
`define UEM_PID_IN 2'h2
`define UEM_PID_SETUP 2'h3
// Answer codes: handshakes and data
`define UEM_RSP_ACK 2'h0
`define UEM_RSP_NAK 2'h1
`define UEM_RSP_STALL 2'h2
`define UEM_RSP_DATA 2'h3
// Internal actions
`define UEM_A_IGN 4'h0
`define UEM_A_SETUP 4'h1
`define UEM_A_NAK 4'h2
`define UEM_A_STALL 4'h3
`define UEM_A_ACKOUT 4'h4
`define UEM_A_CHECK 4'h5
`define UEM_A_ISOOUT 4'h6
`define UEM_A_TX0 4'h7
`define UEM_A_TXCNT 4'h8
`define UEM_A_TXISO 4'h9
// Largest payload: 10 bytes with CRC
`define UEM_MAX_PAYLOAD 4'h8
`endif

// file: hdl/uem_responder.v
// Endpoint mode responder of the serial_interface_engine with Avalon-MM registers
//
// Contract
// - Mode 0000 ignores all tokens, changes no status, raises no interrupt.
// - Accepted valid Setup rewrites mode to 0001.
// - Mode 0001 accepts Setup, NAKs In and Out.
// - 0010 stall In/check Out; 0011 stall both; 0100 ignore; 0110 TX0/stall.
// - Isochronous modes ignore Setup; 0101 always takes Out; 0111 sends count.
// - 1000 NAKs Out; 1001 ACKs Out then becomes 1000.
// - 1010 Setup, TX0 In, NAK Out; 1011 ACKs Out then becomes 1010.
// - 1100 NAKs In; 1101 sends count then becomes 1100 on ACK.
// - 1110 NAK In, check Out; 1111 sends count, becomes 1110 on ACK.
// - Stall flag bit 7 stalls In in 1001 and Out in 1101.
// - Status Out check needs zero bytes and toggle 1.
// - Data packet valid only if at most 10 bytes with CRC and error free.
// - Only valid transactions are answered.
// - Interrupt on valid completion or buffer corruption; a bad packet in the Out check writes the buffer without one.
// - Non-control endpoints ignore Setup.
// - Out endpoints ignore In, In endpoints ignore Out.
// - In/Out bits set at end; Setup bit set at data phase start.
// - ACKed transaction locks mode and count registers against writes.
// - Only a read of the mode or count register after completion releases the lock.
// - Reset to disabled mode; stays until firmware writes.
// - Modes accepting Setup ACK a valid Setup.
// - ACK status bit set on every ACKed transaction.
// - Setup bit held until ACK; CPU clear refused until first read.
// - Count bit 7 is data toggle, bits 5:0 In byte count.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uem_consts.vh"

module uem_responder (
  input wire CLK,
  input wire RST,
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output wire [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire TOK_VALID,
  input wire [1:0] TOK_PID,
  input wire DATA_START,
  input wire DATA_BYTE_VALID,
  input wire [7:0] DATA_BYTE,
  input wire DATA_END,
  input wire DATA_ERR,
  input wire DATA_TOGGLE,
  input wire HS_VALID,
  input wire HS_ACKED,
  output wire RESP_VALID,
  output wire [1:0] RESP_CODE,
  output wire [5:0] TX_COUNT,
  output wire TX_TOGGLE,
  output wire IRQ
);

  localparam S_IDLE = 3'b001;
  localparam S_RX = 3'b010;
  localparam S_TX = 3'b100;

  reg [2:0] st_ff;
  reg [3:0] act_ff;
  reg [7:0] mode_ff;
  reg [7:0] cnt_ff;
  reg ctrl_ff;
  reg lock_ff;
  reg hold_ff;
  reg [3:0] rx_cnt_ff;
  reg wreq_ff;
  reg [31:0] rdata_ff;
  reg resp_valid_ff;
  reg [1:0] resp_code_ff;
  reg [5:0] tx_count_ff;
  reg tx_tog_ff;
  reg irq_ff;
  reg [7:0] buf_mem [0:7];

  ////////////////////////////////////////////////////////////////////
  // Token decode

  function [3:0] act_of;
    input [3:0] m;
    input [1:0] p;
    input c;
    input s;
    begin
      act_of = `UEM_A_IGN;
      if (p == `UEM_PID_SETUP) begin
        case (m)
          `UEM_M_NAK_IO, `UEM_M_ST_OUT, `UEM_M_STALL_IO, `UEM_M_IGN_IO,
          `UEM_M_ST_IN, `UEM_M_NAK_OUT_SI, `UEM_M_ACK_OUT_SI,
          `UEM_M_NAK_IN_SO, `UEM_M_ACK_IN_SO: begin
            if (c)
              act_of = `UEM_A_SETUP;
          end
          default: act_of = `UEM_A_IGN;
        endcase
      end else if (p == `UEM_PID_IN) begin
        case (m)
          `UEM_M_NAK_IO, `UEM_M_NAK_IN, `UEM_M_NAK_IN_SO: act_of = `UEM_A_NAK;
          `UEM_M_ST_OUT, `UEM_M_STALL_IO: act_of = `UEM_A_STALL;
          `UEM_M_ACK_OUT: begin
            if (s)
              act_of = `UEM_A_STALL;
          end
          `UEM_M_ST_IN, `UEM_M_NAK_OUT_SI, `UEM_M_ACK_OUT_SI: act_of = `UEM_A_TX0;
          `UEM_M_ACK_IN, `UEM_M_ACK_IN_SO: act_of = `UEM_A_TXCNT;
          `UEM_M_ISO_IN: act_of = `UEM_A_TXISO;
          default: act_of = `UEM_A_IGN;
        endcase
      end else if (p == `UEM_PID_OUT) begin
        case (m)
          `UEM_M_NAK_IO, `UEM_M_NAK_OUT, `UEM_M_NAK_OUT_SI: act_of = `UEM_A_NAK;
          `UEM_M_STALL_IO, `UEM_M_ST_IN: act_of = `UEM_A_STALL;
          `UEM_M_ACK_IN: begin
            if (s)
              act_of = `UEM_A_STALL;
          end
          `UEM_M_ACK_OUT, `UEM_M_ACK_OUT_SI: act_of = `UEM_A_ACKOUT;
          `UEM_M_ST_OUT, `UEM_M_NAK_IN_SO, `UEM_M_ACK_IN_SO: act_of = `UEM_A_CHECK;
          `UEM_M_ISO_OUT: act_of = `UEM_A_ISOOUT;
          default: act_of = `UEM_A_IGN;
        endcase
      end
    end
  endfunction

  // Actions other than the Out check that receive a data packet into the buffer
  function takes_data;
    input [3:0] a;
    begin
      takes_data = (a == `UEM_A_SETUP) | (a == `UEM_A_ACKOUT) |
                   (a == `UEM_A_ISOOUT);
    end
  endfunction

  // NAKing follow-on of an ACKing mode: the odd mode drops its low bit
  function [3:0] after_ack;
    input [3:0] m;
    begin
      after_ack = {m[3:1], 1'b0};
    end
  endfunction

  // Register decode shared by every select
  function addr_hit;
    input [5:0] addr;
    input [5:0] ofs;
    begin
      addr_hit = addr == ofs;
    end
  endfunction

  // Stall flag only means stall on a non-control endpoint
  wire stall_flag = ~ctrl_ff & mode_ff[`UEM_MB_STALL];
  wire [3:0] nxt_act = act_of(mode_ff[3:0], TOK_PID, ctrl_ff, stall_flag);
  // Counter saturates, so a long packet cannot wrap back to looking valid
  wire rx_over = rx_cnt_ff > `UEM_MAX_PAYLOAD;
  wire rx_ok = ~DATA_ERR & ~rx_over;
  wire stores = takes_data(act_ff) | (act_ff == `UEM_A_CHECK);
  wire status_ok = (rx_cnt_ff == 4'h0) & DATA_TOGGLE;

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  wire bus_req = wreq_ff & (AVS_READ | AVS_WRITE);
  wire sel_mode = addr_hit(AVS_ADDRESS, `UEM_OFS_MODE);
  wire sel_cnt = addr_hit(AVS_ADDRESS, `UEM_OFS_COUNT);
  wire sel_cfg = addr_hit(AVS_ADDRESS, `UEM_OFS_CONFIG);
  wire sel_sts = addr_hit(AVS_ADDRESS, `UEM_OFS_STATUS);
  wire sel_buf = addr_hit(AVS_ADDRESS & `UEM_OFS_BUF, `UEM_OFS_BUF);
  wire [2:0] buf_idx = AVS_ADDRESS[4:2];
  reg [31:0] nxt_rdata;

  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (sel_mode) begin
      nxt_rdata[7:0] = mode_ff;
    end else if (sel_cnt) begin
      nxt_rdata[7:0] = cnt_ff;
    end else if (sel_cfg) begin
      nxt_rdata[0] = ctrl_ff;
    end else if (sel_sts) begin
      nxt_rdata[1:0] = {hold_ff, lock_ff};
    end else if (sel_buf) begin
      nxt_rdata[7:0] = buf_mem[buf_idx];
    end
  end

  // Firmware loses buffer writes while a Setup is pending
  wire cpu_buf_we = bus_req & AVS_WRITE & sel_buf & ~mode_ff[`UEM_MB_SETUP];
  wire rx_buf_we = (st_ff == S_RX) & DATA_BYTE_VALID & stores &
                   (rx_cnt_ff < `UEM_MAX_PAYLOAD);

  always @(posedge CLK) begin
    if (rx_buf_we)
      buf_mem[rx_cnt_ff[2:0]] <= DATA_BYTE;
    else if (cpu_buf_we)
      buf_mem[buf_idx] <= AVS_WRITEDATA[7:0];
  end

  ////////////////////////////////////////////////////////////////////
  // Registers and transaction engine; later assignments win, so the
  // engine's updates beat a firmware write in the same cycle.

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff <= S_IDLE;
      act_ff <= `UEM_A_IGN;
      mode_ff <= `UEM_RST_MODE;
      cnt_ff <= `UEM_RST_COUNT;
      ctrl_ff <= `UEM_RST_CTRL;
      lock_ff <= 1'b0;
      hold_ff <= 1'b0;
      rx_cnt_ff <= 4'h0;
      wreq_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      resp_valid_ff <= 1'b0;
      resp_code_ff <= `UEM_RSP_ACK;
      tx_count_ff <= 6'h00;
      tx_tog_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      resp_valid_ff <= 1'b0;
      irq_ff <= 1'b0;
      // One-cycle answer, then waitrequest rises again
      if (!wreq_ff) begin
        wreq_ff <= 1'b1;
      end else if (bus_req) begin
        wreq_ff <= 1'b0;
        if (AVS_READ) begin
          rdata_ff <= nxt_rdata;
          if (sel_mode | sel_cnt)
            lock_ff <= 1'b0;
          if (sel_mode && st_ff != S_RX)
            hold_ff <= 1'b0;
        end else if (sel_mode) begin
          if (!lock_ff) begin
            mode_ff <= AVS_WRITEDATA[7:0];
            if (hold_ff)
              mode_ff[`UEM_MB_SETUP] <= 1'b1;
            if (!ctrl_ff)
              mode_ff[6:5] <= 2'b00;
          end
        end else if (sel_cnt) begin
          if (!lock_ff)
            cnt_ff <= AVS_WRITEDATA[7:0];
        end else if (sel_cfg) begin
          ctrl_ff <= AVS_WRITEDATA[0];
        end
      end

      case (st_ff)
        S_IDLE: begin
          if (TOK_VALID) begin
            act_ff <= nxt_act;
            rx_cnt_ff <= 4'h0;
            if (TOK_PID != `UEM_PID_IN) begin
              if (nxt_act != `UEM_A_IGN)
                st_ff <= S_RX;
            end else if (nxt_act == `UEM_A_NAK || nxt_act == `UEM_A_STALL) begin
              resp_valid_ff <= 1'b1;
              resp_code_ff <= (nxt_act == `UEM_A_NAK) ? `UEM_RSP_NAK : `UEM_RSP_STALL;
              mode_ff[`UEM_MB_IN] <= ctrl_ff;
              irq_ff <= 1'b1;
              if (mode_ff[3:0] == `UEM_M_ST_OUT)
                mode_ff[3:0] <= `UEM_M_STALL_IO;
            end else if (nxt_act != `UEM_A_IGN) begin
              resp_valid_ff <= 1'b1;
              resp_code_ff <= `UEM_RSP_DATA;
              tx_tog_ff <= cnt_ff[`UEM_CB_TOG];
              tx_count_ff <= (nxt_act == `UEM_A_TX0) ? 6'h00 : cnt_ff[5:0];
              if (nxt_act == `UEM_A_TXISO) begin
                mode_ff[`UEM_MB_IN] <= ctrl_ff;
                irq_ff <= 1'b1;
              end else begin
                st_ff <= S_TX;
              end
            end
          end
        end
        S_RX: begin
          if (DATA_START && act_ff == `UEM_A_SETUP) begin
            mode_ff[`UEM_MB_SETUP] <= 1'b1;
            hold_ff <= 1'b1;
          end
          if (DATA_BYTE_VALID && rx_cnt_ff != 4'hf)
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
          if (DATA_END) begin
            st_ff <= S_IDLE;
            if (takes_data(act_ff)) begin
              // Buffer already overwritten, so report it either way
              irq_ff <= 1'b1;
              cnt_ff <= {DATA_TOGGLE, rx_ok, 2'b00, rx_cnt_ff};
              if (act_ff != `UEM_A_SETUP)
                mode_ff[`UEM_MB_OUT] <= ctrl_ff;
              if (rx_ok && act_ff != `UEM_A_ISOOUT) begin
                resp_valid_ff <= 1'b1;
                resp_code_ff <= `UEM_RSP_ACK;
                mode_ff[`UEM_MB_ACK] <= 1'b1;
                lock_ff <= 1'b1;
                if (act_ff == `UEM_A_SETUP)
                  mode_ff[3:0] <= `UEM_M_NAK_IO;
                else
                  mode_ff[3:0] <= after_ack(mode_ff[3:0]);
              end
            end else if (rx_ok) begin
              irq_ff <= 1'b1;
              resp_valid_ff <= 1'b1;
              mode_ff[`UEM_MB_OUT] <= ctrl_ff;
              if (act_ff == `UEM_A_NAK) begin
                resp_code_ff <= `UEM_RSP_NAK;
              end else if (act_ff == `UEM_A_STALL) begin
                resp_code_ff <= `UEM_RSP_STALL;
                if (mode_ff[3:0] == `UEM_M_ST_IN)
                  mode_ff[3:0] <= `UEM_M_STALL_IO;
              end else begin
                cnt_ff <= {DATA_TOGGLE, 1'b1, 2'b00, rx_cnt_ff};
                if (status_ok) begin
                  resp_code_ff <= `UEM_RSP_ACK;
                  mode_ff[`UEM_MB_ACK] <= 1'b1;
                  lock_ff <= 1'b1;
                end else begin
                  resp_code_ff <= `UEM_RSP_STALL;
                  mode_ff[3:0] <= `UEM_M_STALL_IO;
                end
              end
            end
          end
        end
        // No timeout: a host that never hands back a handshake parks us here
        S_TX: begin
          if (HS_VALID) begin
            st_ff <= S_IDLE;
            if (HS_ACKED) begin
              irq_ff <= 1'b1;
              mode_ff[`UEM_MB_IN] <= ctrl_ff;
              mode_ff[`UEM_MB_ACK] <= 1'b1;
              lock_ff <= 1'b1;
              if (act_ff == `UEM_A_TXCNT)
                mode_ff[3:0] <= after_ack(mode_ff[3:0]);
            end
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  assign AVS_READDATA = rdata_ff;
  assign AVS_WAITREQUEST = wreq_ff;
  assign RESP_VALID = resp_valid_ff;
  assign RESP_CODE = resp_code_ff;
  assign TX_COUNT = tx_count_ff;
  assign TX_TOGGLE = tx_tog_ff;
  assign IRQ = irq_ff;

endmodule // uem_responder
`default_nettype wire

// file: tb/uem_props.sv
// Checker of register bus and link answers of the endpoint responder
`timescale 1ns/1ps
`default_nettype none
`include "uem_consts.vh"
module uem_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic TOK_VALID,
  input wire logic [1:0] TOK_PID,
  input wire logic DATA_END,
  input wire logic DATA_ERR,
  input wire logic HS_VALID,
  input wire logic RESP_VALID,
  input wire logic [1:0] RESP_CODE,
  input wire logic IRQ
);
  // Last token kind, so the answer to a data packet can be tied to its token
  logic [1:0] pid_ff;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) pid_ff <= 2'h0;
    else if (TOK_VALID) pid_ff <= TOK_PID;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  a_wait_one: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("wait low longer than one cycle");
  a_req_served: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered next cycle");
  a_idle_wait: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("answer without request");
  a_resp_cause: assert property (RESP_VALID |-> $past(TOK_VALID) || $past(DATA_END))
    else $error("answer without token or packet");
  a_resp_pulse: assert property (RESP_VALID |=> !RESP_VALID)
    else $error("answer longer than one cycle");
  a_err_silent: assert property (DATA_END && DATA_ERR |=> !RESP_VALID)
    else $error("answer to bad packet");
  a_setup_ack: assert property (DATA_END && pid_ff == `UEM_PID_SETUP |=>
    !RESP_VALID || RESP_CODE == `UEM_RSP_ACK)
    else $error("setup answered other than ack");
  a_in_no_ack: assert property (TOK_VALID && TOK_PID == `UEM_PID_IN |=>
    !RESP_VALID || RESP_CODE != `UEM_RSP_ACK)
    else $error("in token answered with ack");
  a_irq_cause: assert property (IRQ |-> $past(TOK_VALID) || $past(DATA_END) || $past(HS_VALID))
    else $error("interrupt without bus event");
  c_data: cover property (RESP_VALID && RESP_CODE == `UEM_RSP_DATA);
  c_stall: cover property (RESP_VALID && RESP_CODE == `UEM_RSP_STALL);
  c_irq: cover property (IRQ);
endmodule // uem_props
bind uem_responder uem_props u_props (.CLK(CLK), .RST(RST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TOK_VALID(TOK_VALID),
  .TOK_PID(TOK_PID), .DATA_END(DATA_END), .DATA_ERR(DATA_ERR), .HS_VALID(HS_VALID),
  .RESP_VALID(RESP_VALID), .RESP_CODE(RESP_CODE), .IRQ(IRQ));
`default_nettype wire

// file: tb/uem_host.sv
// Behavioural bus host: tokens, data packets and handshakes
`timescale 1ns/1ps
`default_nettype none
module uem_host (
  input wire logic clk,
  output logic tok_valid,
  output logic [1:0] tok_pid,
  output logic data_start,
  output logic byte_valid,
  output logic [7:0] data_byte,
  output logic data_end,
  output logic data_err,
  output logic data_tog,
  output logic hs_valid,
  output logic hs_acked
);
  initial begin
    {tok_valid, tok_pid, data_start, byte_valid, data_byte} = '0;
    {data_end, data_err, data_tog, hs_valid, hs_acked} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tok(input logic [1:0] pid);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_pid <= pid;
    @(posedge clk);
    tok_valid <= 1'b0;
    tok_pid <= ~pid;
  endtask
  // Bytes go out back to back; released lines show inverted junk
  task automatic pkt(input int n, input logic [7:0] base, input logic err, input logic tog);
    @(posedge clk);
    data_start <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      data_start <= 1'b0;
      byte_valid <= 1'b1;
      data_byte <= 8'(base + i);
    end
    @(posedge clk);
    data_start <= 1'b0;
    byte_valid <= 1'b0;
    data_byte <= ~data_byte;
    data_end <= 1'b1;
    data_err <= err;
    data_tog <= tog;
    @(posedge clk);
    data_end <= 1'b0;
    data_err <= ~err;
    data_tog <= ~tog;
  endtask
  task automatic hs(input logic ack);
    @(posedge clk);
    hs_valid <= 1'b1;
    hs_acked <= ack;
    @(posedge clk);
    hs_valid <= 1'b0;
    hs_acked <= ~ack;
  endtask
endmodule // uem_host
`default_nettype wire

// file: tb/uem_responder_tb.sv
// Self-checking bench of the endpoint mode responder
`timescale 1ns/1ps
`default_nettype none
`include "uem_consts.vh"
module uem_responder_tb;
  logic clk, rst, a_rd, a_wr, wreq, rsp_v, tx_tog, irq, got_rsp, got_irq, got_tog;
  logic tv, ds, bv, de, derr, data_toggle_bit, hsv, hsa;
  logic [1:0] tp, rsp_c, got_code;
  logic [5:0] a_addr, tx_cnt, got_cnt;
  logic [7:0] db, base;
  logic [31:0] a_wd, rdata, rd;
  logic [63:0] tab [1:3];
  int n_mismatch = 0, n_compared = 0, cycles = 0, seed, i, m, p;
  uem_responder dut (.CLK(clk), .RST(rst), .AVS_ADDRESS(a_addr), .AVS_READ(a_rd),
    .AVS_WRITE(a_wr), .AVS_WRITEDATA(a_wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .TOK_VALID(tv), .TOK_PID(tp), .DATA_START(ds), .DATA_BYTE_VALID(bv), .DATA_BYTE(db),
    .DATA_END(de), .DATA_ERR(derr), .DATA_TOGGLE(data_toggle_bit), .HS_VALID(hsv), .HS_ACKED(hsa),
    .RESP_VALID(rsp_v), .RESP_CODE(rsp_c), .TX_COUNT(tx_cnt), .TX_TOGGLE(tx_tog), .IRQ(irq));
  uem_host host (.clk(clk), .tok_valid(tv), .tok_pid(tp), .data_start(ds), .byte_valid(bv),
    .data_byte(db), .data_end(de), .data_err(derr), .data_tog(data_toggle_bit), .hs_valid(hsv),
    .hs_acked(hsa));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rsp_v === 1'b1) {got_rsp, got_code, got_cnt, got_tog} <= {1'b1, rsp_c, tx_cnt, tx_tog};
    if (irq === 1'b1) got_irq <= 1'b1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("unexpected at %0t: run too long", $time);
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic av(input logic wr, input logic [5:0] a, input logic [7:0] wd);
    @(posedge clk);
    {a_addr, a_rd, a_wr, a_wd} <= {a, !wr, wr, 24'h0, wd};
    do @(posedge clk); while (wreq !== 1'b0);
    rd = rdata;
    {a_rd, a_wr} <= 2'b00;
  endtask
  task automatic xfer(input logic [1:0] pk, input int n, input logic [7:0] b, input logic e,
    input logic t);
    {got_rsp, got_irq} = 2'b00;
    host.tok(pk);
    if (pk != `UEM_PID_IN) host.pkt(n, b, e, t);
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Model of the mode the engine leaves behind after one answered token
  function automatic logic [3:0] nxt(input logic [3:0] md, input int pk, input logic [2:0] c);
    if (c == 3'h4) return md;
    if (pk == `UEM_PID_SETUP) return 4'h1;
    if (pk == `UEM_PID_IN && (md == 4'hd || md == 4'hf)) return md - 4'h1;
    if (pk == `UEM_PID_OUT && (md == 4'h9 || md == 4'hb)) return md - 4'h1;
    if ((pk == `UEM_PID_IN && md == 4'h2) || (pk == `UEM_PID_OUT && md == 4'h6)) return 4'h3;
    return md;
  endfunction
  task automatic trial(input logic [7:0] mw, input int pk, input logic [2:0] ex);
    logic [6:0] cnt;
    cnt = {1'($random(seed)), 6'({$random(seed)} % 33)};
    av(1'b1, 6'h04, {cnt[6], 1'b0, cnt[5:0]});
    av(1'b1, 6'h00, mw);
    xfer(2'(pk), (pk == `UEM_PID_SETUP) ? 8 : 0, 8'h3c, 1'b0, pk != `UEM_PID_SETUP);
    chk(got_rsp ? {1'b0, got_code} : 3'h4, ex);
    if (got_rsp && got_code == `UEM_RSP_DATA) begin
      chk(got_cnt, (mw[3:0] == 4'h7 || mw[3:0] > 4'hc) ? cnt[5:0] : 6'h0);
      chk(got_tog, cnt[6]);
      if (mw[3:0] != 4'h7) host.hs(1'b1);
      repeat (2) @(posedge clk);
    end
    if (mw == 8'h00) chk(got_irq, 1'b0);
    av(1'b0, 6'h00, 8'h00);
    chk(rd[3:0], nxt(mw[3:0], pk, ex));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h89fb1c16;
    rst = 1'b1;
    {a_addr, a_rd, a_wr, a_wd} = '0;
    tab[1] = 64'h0044_0101_4244_2014;
    tab[2] = 64'h3131_3344_3344_2214;
    tab[3] = 64'h0044_0044_4040_0004;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) begin
      av(1'b0, 6'(i * 4), 8'h00);
      chk(rd, (i == 2) ? 32'h1 : 32'h0);
    end
    $display("test reset values done");
    for (p = 1; p < 4; p++) begin
      for (m = 0; m < 16; m++) trial(8'(m), p, tab[p][m * 4 +: 3]);
    end
    $display("test mode table done");
    av(1'b1, 6'h08, 8'h00);
    trial(8'h89, `UEM_PID_IN, 3'h2);
    trial(8'h8d, `UEM_PID_OUT, 3'h2);
    av(1'b1, 6'h08, 8'h01);
    $display("test stall flag done");
    base = 8'($random(seed));
    av(1'b1, 6'h00, 8'h09);
    xfer(`UEM_PID_OUT, 8, base, 1'b1, 1'b0);
    chk({got_rsp, got_irq}, 2'b01);
    av(1'b0, 6'h04, 8'h00);
    chk(rd[6], 1'b0);
    xfer(`UEM_PID_OUT, 9, base, 1'b0, 1'b0);
    chk(got_rsp, 1'b0);
    xfer(`UEM_PID_OUT, 8, base, 1'b0, 1'b1);
    chk({got_rsp, got_code, got_irq}, {1'b1, `UEM_RSP_ACK, 1'b1});
    for (i = 0; i < 8; i++) begin
      av(1'b0, 6'h20 + 6'(i * 4), 8'h00);
      chk(rd, {24'h0, 8'(base + i)});
    end
    av(1'b0, 6'h04, 8'h00);
    chk(rd[7:6], 2'b11);
    av(1'b1, 6'h00, 8'h0e);
    xfer(`UEM_PID_OUT, 0, base, 1'b0, 1'b0);
    chk({got_rsp, got_code}, {1'b1, `UEM_RSP_STALL});
    av(1'b0, 6'h00, 8'h00);
    chk(rd[3:0], 4'h3);
    $display("test packet validity done");
    av(1'b1, 6'h04, 8'h05);
    av(1'b1, 6'h00, 8'h0d);
    xfer(`UEM_PID_IN, 0, 8'h00, 1'b0, 1'b0);
    av(1'b0, 6'h00, 8'h00);
    host.hs(1'b1);
    av(1'b1, 6'h00, 8'h01);
    av(1'b0, 6'h0c, 8'h00);
    chk(rd[0], 1'b1);
    av(1'b0, 6'h00, 8'h00);
    chk(rd[4:0], 5'h1c);
    av(1'b0, 6'h0c, 8'h00);
    chk(rd[0], 1'b0);
    $display("test register lock done");
    close_out();
  end
endmodule // uem_responder_tb
`default_nettype wire
